// ===== hdl/rse_pkg.sv
// constants and types of the receive signaling extractor
// assumes a byte-wide register map on a 32-bit classic wishbone slave
package rse_pkg;

   localparam int NUM_CHAN = 24;

   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_CONFIG = 8'hd2;
   localparam logic [7:0] IDX_STATUS = 8'hd3;
   localparam logic [7:0] IDX_CONTROL = 8'hd4;
   localparam logic [7:0] IDX_DATA = 8'hd5;
   localparam logic [7:0] IDX_FLAGS_LOW = 8'hd6;
   localparam logic [7:0] IDX_FLAGS_MID = 8'hd7;
   localparam logic [7:0] IDX_FLAGS_HIGH = 8'hd8;

   // field positions
   localparam int CFG_FREEZE_BIT = 3;
   localparam int CFG_DEBOUNCE_BIT = 2;
   localparam int CFG_IRQ_BIT = 1;
   localparam int CFG_SIXTEEN_BIT = 0;
   localparam logic [7:0] CFG_MASK = 8'h0f;
   localparam int STATUS_BUSY_BIT = 0;
   localparam int CTL_DIR_BIT = 7;
   localparam int EXT_EN_BIT = 4;

   // reset values
   localparam logic [7:0] CONFIG_RESET = 8'h01;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [23:0] FLAGS_RESET = 24'h000000;
   localparam logic EXTRACT_RESET = 1'b1;
   localparam logic [3:0] NIBBLE_RESET = 4'h0;

   // indirect address range, one address per channel
   localparam logic [6:0] IND_ADDR_FIRST = 7'h01;
   localparam logic [6:0] IND_ADDR_LAST = 7'h18;

   // signaling frames within a multiframe
   localparam logic [4:0] FRAME_A = 5'h06;
   localparam logic [4:0] FRAME_B = 5'h0c;
   localparam logic [4:0] FRAME_C = 5'h12;
   localparam logic [4:0] FRAME_D = 5'h18;

   typedef enum logic [1:0]
   {
      FMT_SF = 2'h0,
      FMT_ESF = 2'h1,
      FMT_SLC96 = 2'h2,
      FMT_DM = 2'h3
   } rse_format_type;

   typedef enum logic [1:0]
   {
      ACC_IDLE = 2'b01,
      ACC_RUN = 2'b10
   } rse_acc_state_type;

endpackage

// ===== hdl/rse_code_if.sv
// completed signaling codeword, one channel at a time
// assumes one source (capture) and any number of channel cells
`timescale 1ns/10ps
interface rse_code_if;
   logic valid;
   logic [4:0] chan;
   logic [3:0] code;
   modport src (output valid, output chan, output code);
   modport dst (input valid, input chan, input code);
endinterface

// ===== hdl/rse_capture.sv
// assembles per-channel abcd codewords from the received signaling bits
// assumes the framer gives frame number 1..24 and channel 0..23 per bit
`timescale 1ns/10ps
module rse_capture
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sig_valid_i,
   input wire logic [4:0] sig_chan_i,
   input wire logic [4:0] sig_frame_i,
   input wire logic sig_bit_i,
   input wire logic frame_sync_i,
   input wire rse_pkg::rse_format_type format_i,
   input wire logic sixteen_state_i,
   rse_code_if.src code
);

   typedef struct packed
   {
      logic [95:0] part;
      logic valid;
      logic [4:0] chan;
      logic [3:0] code;
   } rse_cap_state_type;

   rse_cap_state_type st_q;
   rse_cap_state_type st_d;

   always_comb
   begin
      logic [3:0] cur;
      logic [6:0] base;
      cur = 4'h0;
      base = {sig_chan_i, 2'b00};
      st_d = st_q;
      st_d.valid = 1'b0;
      // no signaling in dm, and nothing is taken while out of sync
      if (sig_valid_i && frame_sync_i && format_i != rse_pkg::FMT_DM &&
          sig_chan_i < 5'(rse_pkg::NUM_CHAN))
      begin
         cur = st_q.part[base +: 4];
         st_d.chan = sig_chan_i;
         case (sig_frame_i)
            rse_pkg::FRAME_A:
               cur[3] = sig_bit_i;
            rse_pkg::FRAME_B:
            begin
               cur[2] = sig_bit_i;
               if (format_i == rse_pkg::FMT_SF)
               begin
                  st_d.valid = 1'b1;
                  st_d.code = {cur[3], sig_bit_i, cur[3], sig_bit_i};
               end
            end
            rse_pkg::FRAME_C:
               if (sixteen_state_i)
                  cur[1] = sig_bit_i;
               else
                  cur[3] = sig_bit_i;
            rse_pkg::FRAME_D:
            begin
               if (sixteen_state_i)
                  cur[0] = sig_bit_i;
               else
                  cur[2] = sig_bit_i;
               st_d.valid = 1'b1;
               // four-state mode keeps c and d at zero, frames C and D carry a and b again
               st_d.code = sixteen_state_i ? cur : {cur[3:2], 2'b00};
            end
            default:
               cur = st_q.part[base +: 4];
         endcase
         st_d.part[base +: 4] = cur;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign code.valid = st_q.valid;
   assign code.chan = st_q.chan;
   assign code.code = st_q.code;

endmodule

// ===== hdl/rse_cell.sv
// one channel: extract enable, debounce, freeze and stored abcd nibble
// assumes codewords arrive at most once per cycle over rse_code_if
`timescale 1ns/10ps
module rse_cell
#(
   parameter logic [4:0] CHAN = 5'h00
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   rse_code_if.dst code,
   input wire logic freeze_i,
   input wire logic debounce_i,
   input wire logic en_wr_i,
   input wire logic en_data_i,
   output logic [3:0] nibble_o,
   output logic extract_en_o,
   output logic change_o
);

   typedef struct packed
   {
      logic [3:0] nib;
      logic [3:0] prev;
      logic en;
      logic change;
   } rse_cell_state_type;

   rse_cell_state_type st_q;
   rse_cell_state_type st_d;

   always_comb
   begin
      st_d = st_q;
      st_d.change = 1'b0;
      if (en_wr_i)
         st_d.en = en_data_i;
      if (code.valid && code.chan == CHAN && st_q.en)
      begin
         // the last codeword is kept even while frozen so debounce resumes
         st_d.prev = code.code;
         if (!freeze_i && (!debounce_i || code.code == st_q.prev) &&
             code.code != st_q.nib)
         begin
            st_d.nib = code.code;
            st_d.change = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_q.nib <= rse_pkg::NIBBLE_RESET;
         st_q.prev <= rse_pkg::NIBBLE_RESET;
         st_q.en <= rse_pkg::EXTRACT_RESET;
         st_q.change <= 1'b0;
      end
      else
         st_q <= st_d;
   end

   assign nibble_o = st_q.nib;
   assign extract_en_o = st_q.en;
   assign change_o = st_q.change;

endmodule

// ===== hdl/rse_top.sv
// receive signaling extractor: wishbone registers, indirect access, flags
// assumes framer inputs share clk_i; 24 channel cells and one capture unit
`timescale 1ns/10ps
module rse_top
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic sig_valid_i,
   input wire logic [4:0] sig_chan_i,
   input wire logic [4:0] sig_frame_i,
   input wire logic sig_bit_i,
   input wire logic frame_sync_i,
   input wire rse_pkg::rse_format_type format_i,
   output logic irq_o
);

   typedef struct packed
   {
      logic [7:0] cfg;
      logic [7:0] ctl;
      logic [7:0] data;
      logic [23:0] flags;
      rse_pkg::rse_acc_state_type acc;
      logic ack;
      logic [31:0] rdat;
      logic irq;
   } rse_top_state_type;

   rse_top_state_type st_q;
   rse_top_state_type st_d;

   logic [3:0] nibble [rse_pkg::NUM_CHAN];
   logic [rse_pkg::NUM_CHAN-1:0] extract_en;
   logic [rse_pkg::NUM_CHAN-1:0] change;
   logic [rse_pkg::NUM_CHAN-1:0] en_wr;
   logic [6:0] ind_addr;
   logic ind_valid;
   logic [4:0] ind_chan;

   rse_code_if code_bus ();

   rse_capture u_capture
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sig_valid_i(sig_valid_i),
      .sig_chan_i(sig_chan_i),
      .sig_frame_i(sig_frame_i),
      .sig_bit_i(sig_bit_i),
      .frame_sync_i(frame_sync_i),
      .format_i(format_i),
      .sixteen_state_i(st_q.cfg[rse_pkg::CFG_SIXTEEN_BIT]),
      .code(code_bus.src)
   );

   // indirect address decode, shared by the read mux and enable writes
   assign ind_addr = st_q.ctl[6:0];
   assign ind_valid = ind_addr >= rse_pkg::IND_ADDR_FIRST &&
                      ind_addr <= rse_pkg::IND_ADDR_LAST;
   assign ind_chan = 5'(ind_addr - rse_pkg::IND_ADDR_FIRST);

   genvar gi;
   generate
      for (gi = 0; gi < rse_pkg::NUM_CHAN; gi++)
      begin : g_chan
         // enable bit written in the run cycle of an indirect write
         assign en_wr[gi] = st_q.acc == rse_pkg::ACC_RUN &&
                            !st_q.ctl[rse_pkg::CTL_DIR_BIT] && ind_valid &&
                            ind_chan == 5'(gi);

         rse_cell #(.CHAN(5'(gi))) u_cell
         (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .code(code_bus.dst),
            .freeze_i(st_q.cfg[rse_pkg::CFG_FREEZE_BIT]),
            .debounce_i(st_q.cfg[rse_pkg::CFG_DEBOUNCE_BIT]),
            .en_wr_i(en_wr[gi]),
            .en_data_i(st_q.data[rse_pkg::EXT_EN_BIT]),
            .nibble_o(nibble[gi]),
            .extract_en_o(extract_en[gi]),
            .change_o(change[gi])
         );
      end
   endgenerate

   always_comb
   begin
      logic req;
      logic wr;
      logic hit;
      logic [7:0] idx;
      logic [7:0] rd;
      logic [23:0] clr;
      req = wb_cyc_i && wb_stb_i && !st_q.ack;
      // only byte lane 0 carries register data; other lanes are ignored
      wr = req && wb_we_i && wb_sel_i[0];
      hit = wb_adr_i[11:10] == 2'b00;
      idx = wb_adr_i[9:2];
      rd = 8'h00;
      clr = 24'h000000;
      st_d = st_q;
      st_d.ack = 1'b0;

      if (hit)
      begin
         case (idx)
            rse_pkg::IDX_CONFIG:
               rd = st_q.cfg & rse_pkg::CFG_MASK;
            rse_pkg::IDX_STATUS:
               rd[rse_pkg::STATUS_BUSY_BIT] =
                  st_q.acc != rse_pkg::ACC_IDLE;
            rse_pkg::IDX_CONTROL:
               rd = st_q.ctl;
            rse_pkg::IDX_DATA:
               rd = st_q.data;
            rse_pkg::IDX_FLAGS_LOW:
               rd = st_q.flags[7:0];
            rse_pkg::IDX_FLAGS_MID:
               rd = st_q.flags[15:8];
            rse_pkg::IDX_FLAGS_HIGH:
               rd = st_q.flags[23:16];
            default:
               rd = 8'h00;
         endcase
      end

      // unmapped addresses are acked with zero and writes dropped
      if (req)
      begin
         st_d.ack = 1'b1;
         st_d.rdat = {24'h000000, rd};
      end

      if (wr && hit)
      begin
         case (idx)
            rse_pkg::IDX_CONFIG:
               st_d.cfg = wb_dat_i[7:0] & rse_pkg::CFG_MASK;
            rse_pkg::IDX_CONTROL:
               // a request while busy is dropped, the host must wait
               if (st_q.acc == rse_pkg::ACC_IDLE)
               begin
                  st_d.ctl = wb_dat_i[7:0];
                  st_d.acc = rse_pkg::ACC_RUN;
               end
            rse_pkg::IDX_DATA:
               st_d.data = wb_dat_i[7:0];
            rse_pkg::IDX_FLAGS_LOW:
               clr[7:0] = wb_dat_i[7:0];
            rse_pkg::IDX_FLAGS_MID:
               clr[15:8] = wb_dat_i[7:0];
            rse_pkg::IDX_FLAGS_HIGH:
               clr[23:16] = wb_dat_i[7:0];
            default:
               clr = 24'h000000;
         endcase
      end

      case (st_q.acc)
         rse_pkg::ACC_IDLE:
            st_d.acc = st_d.acc;
         rse_pkg::ACC_RUN:
         begin
            if (st_q.ctl[rse_pkg::CTL_DIR_BIT])
            begin
               // out-of-range reads return zero
               st_d.data = ind_valid ?
                  {3'b000, extract_en[ind_chan], nibble[ind_chan]} :
                  8'h00;
            end
            st_d.acc = rse_pkg::ACC_IDLE;
         end
         default:
            st_d.acc = rse_pkg::ACC_IDLE;
      endcase

      // a change in the clearing cycle wins over the clear
      st_d.flags = (st_q.flags & ~clr) | change;
      st_d.irq = st_d.cfg[rse_pkg::CFG_IRQ_BIT] && (|st_d.flags);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_q.cfg <= rse_pkg::CONFIG_RESET;
         st_q.ctl <= rse_pkg::CONTROL_RESET;
         st_q.data <= rse_pkg::DATA_RESET;
         st_q.flags <= rse_pkg::FLAGS_RESET;
         st_q.acc <= rse_pkg::ACC_IDLE;
         st_q.ack <= 1'b0;
         st_q.rdat <= 32'h00000000;
         st_q.irq <= 1'b0;
      end
      else
         st_q <= st_d;
   end

   assign wb_dat_o = st_q.rdat;
   assign wb_ack_o = st_q.ack;
   assign irq_o = st_q.irq;

endmodule

// ===== bench/rse_checker.sv
// register port and interrupt checks of the signaling extractor
// assumes a bind to rse_top; sees its register port and irq only
`timescale 1ns/10ps
module rse_checker
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic irq_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // shadow of the config bits, kept from bus writes alone
   logic [3:0] cfg_q;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         cfg_q <= 4'h1;
      else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
         && wb_adr_i == 12'h348)
         cfg_q <= wb_dat_i[3:0];
   end
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_read(logic [11:0] a);
      wb_ack_o && !wb_we_i && wb_adr_i == a;
   endsequence
   chk_ack_prompt: assert property (s_req |=> wb_ack_o)
      else $error("request not acknowledged");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i))
      else $error("ack without request");
   chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("upper read bits not zero");
   chk_busy_done: assert property (s_read(12'h34c) |-> wb_dat_o == 32'h0)
      else $error("busy still set or reserved status bit set");
   chk_config_back: assert property (s_read(12'h348) |->
      wb_dat_o[7:0] == {4'h0, cfg_q})
      else $error("config readback differs");
   chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i &&
      wb_adr_i[11:10] != 2'b00 |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   chk_irq_masked: assert property (!cfg_q[1] ##1 !cfg_q[1] |-> !irq_o)
      else $error("irq high while disabled");
   chk_irq_rise: assert property ($rose(irq_o) |-> cfg_q[1])
      else $error("irq rose while disabled");
endmodule

// ===== bench/rse_framer_model.sv
// framer-side model: robbed signaling bits of one channel
// assumes send is called right after a rising edge of clk_i
`timescale 1ns/10ps
module rse_framer_model
(
   input wire logic clk_i,
   output logic sig_valid_o,
   output logic [4:0] sig_chan_o,
   output logic [4:0] sig_frame_o,
   output logic sig_bit_o
);
   initial
   begin
      sig_valid_o = 1'b0;
      sig_chan_o = 5'h00;
      sig_frame_o = 5'h00;
      sig_bit_o = 1'b0;
   end
   // bits on frames 6, 12, 18, 24; the line is inverted between bits
   // so a stale level never passes for a held signaling bit
   task automatic send(input logic [4:0] ch, input logic [3:0] abcd,
      input int nfr);
      for (int i = 1; i <= nfr; i++)
      begin
         sig_valid_o <= 1'b1;
         sig_chan_o <= ch;
         sig_frame_o <= 5'(6 * i);
         sig_bit_o <= abcd[4 - i];
         @(posedge clk_i);
         sig_valid_o <= 1'b0;
         sig_bit_o <= ~abcd[4 - i];
         @(posedge clk_i);
      end
   endtask
endmodule

// ===== bench/rse_top_test.sv
// self-checking bench of the receive signaling extractor
// assumes rse_top, the framer model and the checker
`timescale 1ns/10ps
module rse_top_test;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [11:0] wb_adr_i = 12'h000;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, irq_o, sig_valid_i, sig_bit_i;
   logic [4:0] sig_chan_i, sig_frame_i;
   logic frame_sync_i = 1'b1;
   rse_pkg::rse_format_type format_i = rse_pkg::FMT_ESF;
   int mismatches = 0;
   int num_checks = 0;
   int cycles = 0;
   logic [7:0] exp_q[$];
   logic [4:0] ch;
   logic [3:0] v;
   logic [1:0] u;
   always #50 clk_i = ~clk_i;
   rse_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .sig_valid_i(sig_valid_i),
      .sig_chan_i(sig_chan_i), .sig_frame_i(sig_frame_i),
      .sig_bit_i(sig_bit_i), .frame_sync_i(frame_sync_i),
      .format_i(format_i), .irq_o(irq_o));
   rse_framer_model fr (.clk_i(clk_i), .sig_valid_o(sig_valid_i),
      .sig_chan_o(sig_chan_i), .sig_frame_o(sig_frame_i),
      .sig_bit_o(sig_bit_i));
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic cmp_val(input logic [31:0] got, input logic [31:0] e);
      num_checks++;
      if (got !== e)
      begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, e);
      end
   endtask
   // read results are matched in order of issue
   always @(posedge clk_i)
   begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
         cmp_val(wb_dat_o, {24'h0, exp_q.pop_front()});
   end
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         mismatches++;
         conclude();
      end
   end
   task automatic bus(input logic w, input logic [9:0] idx,
      input logic [7:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= {idx, 2'b00};
      wb_sel_i <= 4'h1;
      wb_dat_i <= {24'h0, d};
      // no own limit: only the cycle ceiling ends a hung wait
      do
         @(posedge clk_i);
      while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask
   task automatic rd(input logic [9:0] idx, input logic [7:0] e);
      exp_q.push_back(e);
      bus(1'b0, idx, 8'h00);
   endtask
   // indirect read; busy is read once and expected clear before the data read
   task automatic ind(input logic [6:0] a, input logic [7:0] e);
      wr(10'h0d4, {1'b1, a});
      rd(10'h0d3, 8'h00);
      rd(10'h0d5, e);
   endtask
   task automatic sig(input logic [3:0] nib, input int nfr);
      fr.send(ch, nib, nfr);
      repeat (4) @(posedge clk_i);
   endtask
   function automatic logic [9:0] fidx(input logic [4:0] c);
      return 10'h0d6 + 10'(c[4:3]);
   endfunction
   task automatic flag(input logic b);
      rd(fidx(ch), 8'(b) << ch[2:0]);
   endtask
   initial
   begin
      v = 4'($urandom(32'h64d248b2));
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(10'h0d2, 8'h01);
      for (int i = 3; i < 9; i++)
         rd(10'h0d0 + 10'(i), 8'h00);
      rd(10'h300, 8'h00);
      ind(7'h05, 8'h10);
      ind(7'h19, 8'h00);
      wr(10'h0d5, 8'h00);
      wr(10'h0d4, 8'h07);
      ind(7'h07, 8'h00);
      $display("test registers finished at %0t", $time);
      ch = 5'($urandom_range(23, 8));
      v = 4'($urandom_range(15, 1));
      wr(10'h0d2, 8'h03);
      sig(v, 4);
      cmp_val({31'h0, irq_o}, 32'h1);
      flag(1'b1);
      wr(fidx(ch), 8'h00);
      flag(1'b1);
      wr(fidx(ch), 8'hff);
      flag(1'b0);
      cmp_val({31'h0, irq_o}, 32'h0);
      ind(7'(ch) + 7'h01, {4'h1, v});
      u = 2'($urandom_range(3, 0));
      wr(10'h0d2, 8'h00);
      sig({u, u}, 4);
      ind(7'(ch) + 7'h01, {4'h1, u, 2'b00});
      format_i <= rse_pkg::FMT_SF;
      sig({~u, u}, 2);
      ind(7'(ch) + 7'h01, {4'h1, ~u, ~u});
      $display("test formats finished at %0t", $time);
      format_i <= rse_pkg::FMT_SLC96;
      wr(fidx(ch), 8'hff);
      wr(10'h0d2, 8'h09);
      sig({u, u}, 4);
      ind(7'(ch) + 7'h01, {4'h1, ~u, ~u});
      flag(1'b0);
      wr(10'h0d2, 8'h05);
      sig({~u, ~u} ^ 4'h5, 4);
      ind(7'(ch) + 7'h01, {4'h1, ~u, ~u});
      sig({~u, ~u} ^ 4'h5, 4);
      ind(7'(ch) + 7'h01, {4'h1, {~u, ~u} ^ 4'h5});
      flag(1'b1);
      wr(10'h0d2, 8'h01);
      frame_sync_i <= 1'b0;
      sig({u, u}, 4);
      ind(7'(ch) + 7'h01, {4'h1, {~u, ~u} ^ 4'h5});
      frame_sync_i <= 1'b1;
      format_i <= rse_pkg::FMT_DM;
      sig({u, u}, 4);
      ind(7'(ch) + 7'h01, {4'h1, {~u, ~u} ^ 4'h5});
      wr(10'h0d5, 8'h00);
      wr(10'h0d4, {1'b0, 7'(ch) + 7'h01});
      format_i <= rse_pkg::FMT_ESF;
      sig({u, u}, 4);
      ind(7'(ch) + 7'h01, {4'h0, {~u, ~u} ^ 4'h5});
      $display("test extraction finished at %0t", $time);
      conclude();
   end
endmodule
bind rse_top rse_checker chk (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));
